/* File: common/iosc_pkg.sv */
// Purpose: Shared constants and types for the internal oscillator and clock multiplier control
// Assumes: 8-bit special-function register port, 125 MHz core clock
// Notes: Trim reset values stand in for the factory calibration
package iosc_pkg;
  localparam logic [7:0] ADDR_SRC_SEL = 8'h8f;
  localparam logic [7:0] ADDR_MULT = 8'h97;
  localparam logic [7:0] ADDR_FINE = 8'h9e;
  localparam logic [7:0] ADDR_OSC_CTRL = 8'ha1;
  localparam logic [7:0] ADDR_COARSE = 8'ha2;
  localparam int OSC_EN_LSB = 6;
  localparam int SUSP_BIT = 5;
  localparam int FRDY_BIT = 4;
  localparam int MUL_EN_BIT = 7;
  localparam int MUL_INIT_BIT = 6;
  localparam int MUL_RDY_BIT = 5;
  localparam int SCALE_LSB = 2;
  localparam logic [1:0] OSC_EN_OFF = 2'h0;
  localparam logic [1:0] OSC_EN_ON = 2'h3;
  localparam logic [1:0] OSC_EN_RST = 2'h3;
  localparam logic [2:0] DIV_RST = 3'h0;
  localparam logic [2:0] DIV_BY_ONE = 3'h7;
  localparam logic [6:0] COARSE_RST = 7'h40;
  localparam logic [5:0] FINE_RST = 6'h20;
  localparam logic [7:0] MULT_RST = 8'h00;
  localparam logic [1:0] SRC_INT = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_MULT = 2'h2;
  localparam logic [1:0] SRC_RSVD = 2'h3;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int OSC_SETTLE_NS = 1000;
  localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } iosc_sfr_t;

  typedef struct packed {
    logic run;
    logic [6:0] coarse;
    logic [5:0] fine;
  } iosc_trim_t;

  typedef struct packed {
    logic en;
    logic init;
    logic src_ext;
    logic base_x4;
    logic [2:0] num;
    logic [2:0] den;
  } iosc_mult_t;
endpackage

/* File: rtl/iosc_ctrl.sv */
// Purpose: Register file and control for internal oscillator, divider and clock multiplier
// Assumes: Analog oscillator and loop take the trim and multiplier controls; lock comes back synchronous
// Notes: The oscillator is modelled by the core clock; the tick marks each divided system clock edge
`timescale 1ns/1ps
module iosc_ctrl #(
  parameter logic [6:0] COARSE_INIT = iosc_pkg::COARSE_RST,
  parameter logic [5:0] FINE_INIT = iosc_pkg::FINE_RST,
  parameter int SETTLE_CYC = iosc_pkg::OSC_SETTLE_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire iosc_pkg::iosc_sfr_t sfr_i,
  input wire logic port0_match_i,
  input wire logic port1_match_i,
  input wire logic cmp0_en_i,
  input wire logic cmp0_out_i,
  input wire logic pll_lock_i,
  output logic [7:0] sfr_rdata_o,
  output iosc_pkg::iosc_trim_t osc_o,
  output iosc_pkg::iosc_mult_t mult_o,
  output logic [1:0] system_clock_src_o,
  output logic system_clock_tick_o,
  output logic system_clock_stop_o
);
  import iosc_pkg::*;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_SETTLE = 3'b010,
    ST_READY = 3'b100
  } iosc_osc_st_t;

  // Low bits that must match for a tick at a given divider code
  function automatic logic [6:0] div_mask(input logic [2:0] code);
    div_mask = 7'(8'h80 >> code) - 7'h01;
    if (code == 3'h0) begin
      div_mask = 7'h7f;
    end
  endfunction

  function automatic logic wr_hit(input iosc_sfr_t b, input logic [7:0] a);
    wr_hit = b.wr && (b.addr == a);
  endfunction

  function automatic logic rd_hit(input iosc_sfr_t b, input logic [7:0] a);
    rd_hit = b.rd && (b.addr == a);
  endfunction

  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  logic rst_n;
  assign rst_n = rst_sync_reg;

  // Register state
  logic [1:0] osc_en_reg, osc_en_next;
  logic susp_reg, susp_next;
  logic [2:0] div_reg, div_next;
  logic [6:0] coarse_reg, coarse_next;
  logic [5:0] fine_reg, fine_next;
  logic [1:0] src_reg, src_next;
  logic mul_en_reg, mul_en_next;
  logic mul_init_reg, mul_init_next;
  logic [2:0] scale_reg, scale_next;
  logic [1:0] msel_reg, msel_next;
  logic mul_armed_reg, mul_armed_next;
  logic mul_rdy_reg, mul_rdy_next;
  logic [7:0] rdata_reg, rdata_next;
  logic wake;
  logic osc_run;
  logic frdy;

  assign wake = port0_match_i || port1_match_i || (cmp0_en_i && !cmp0_out_i);
  assign osc_run = (osc_en_reg == OSC_EN_ON) && !susp_reg;

  always_comb begin
    osc_en_next = osc_en_reg;
    susp_next = susp_reg;
    div_next = div_reg;
    coarse_next = coarse_reg;
    fine_next = fine_reg;
    src_next = src_reg;
    mul_en_next = mul_en_reg;
    mul_init_next = mul_init_reg;
    scale_next = scale_reg;
    msel_next = msel_reg;
    mul_armed_next = mul_armed_reg;
    rdata_next = 8'h00;
    if (wake) begin
      susp_next = 1'b0;
    end
    if (wr_hit(sfr_i, ADDR_OSC_CTRL)) begin
      osc_en_next = sfr_i.wdata[OSC_EN_LSB +: 2];
      if (sfr_i.wdata[SUSP_BIT]) begin
        susp_next = 1'b1;
      end
      div_next = sfr_i.wdata[2:0];
    end
    if (wr_hit(sfr_i, ADDR_COARSE)) begin
      coarse_next = sfr_i.wdata[6:0];
    end
    if (wr_hit(sfr_i, ADDR_FINE)) begin
      fine_next = sfr_i.wdata[5:0];
    end
    if (wr_hit(sfr_i, ADDR_SRC_SEL) && (sfr_i.wdata[1:0] != SRC_RSVD)) begin
      src_next = sfr_i.wdata[1:0];
    end
    if (wr_hit(sfr_i, ADDR_MULT)) begin
      mul_en_next = sfr_i.wdata[MUL_EN_BIT];
      mul_init_next = sfr_i.wdata[MUL_INIT_BIT];
      scale_next = sfr_i.wdata[SCALE_LSB +: 3];
      msel_next = sfr_i.wdata[1:0];
      // Initialise only counts with enable held in the same value
      mul_armed_next = sfr_i.wdata[MUL_EN_BIT] && sfr_i.wdata[MUL_INIT_BIT];
    end
    if (!mul_en_next) begin
      mul_armed_next = 1'b0;
    end
    case (1'b1)
      rd_hit(sfr_i, ADDR_OSC_CTRL): rdata_next = {osc_en_reg, susp_reg, frdy, 1'b0, div_reg};
      rd_hit(sfr_i, ADDR_COARSE): rdata_next = {1'b0, coarse_reg};
      rd_hit(sfr_i, ADDR_FINE): rdata_next = {2'h0, fine_reg};
      rd_hit(sfr_i, ADDR_SRC_SEL): rdata_next = {6'h00, src_reg};
      rd_hit(sfr_i, ADDR_MULT): rdata_next = {mul_en_reg, mul_init_reg, mul_rdy_reg, scale_reg, msel_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  assign mul_rdy_next = mul_armed_reg && mul_en_reg && pll_lock_i;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      osc_en_reg <= OSC_EN_RST;
      susp_reg <= 1'b0;
      div_reg <= DIV_RST;
      coarse_reg <= COARSE_INIT;
      fine_reg <= FINE_INIT;
      src_reg <= SRC_INT;
      mul_en_reg <= MULT_RST[MUL_EN_BIT];
      mul_init_reg <= MULT_RST[MUL_INIT_BIT];
      scale_reg <= MULT_RST[SCALE_LSB +: 3];
      msel_reg <= MULT_RST[1:0];
      mul_armed_reg <= 1'b0;
      mul_rdy_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      osc_en_reg <= osc_en_next;
      susp_reg <= susp_next;
      div_reg <= div_next;
      coarse_reg <= coarse_next;
      fine_reg <= fine_next;
      src_reg <= src_next;
      mul_en_reg <= mul_en_next;
      mul_init_reg <= mul_init_next;
      scale_reg <= scale_next;
      msel_reg <= msel_next;
      mul_armed_reg <= mul_armed_next;
      mul_rdy_reg <= mul_rdy_next;
      rdata_reg <= rdata_next;
    end
  end

  // Oscillator settle tracking and divider
  iosc_osc_st_t st_reg, st_next;
  logic [15:0] settle_reg, settle_next;
  logic [6:0] div_cnt_reg, div_cnt_next;
  logic tick_reg, tick_next;

  always_comb begin
    st_next = st_reg;
    settle_next = settle_reg;
    div_cnt_next = div_cnt_reg;
    tick_next = 1'b0;
    case (st_reg)
      ST_OFF: begin
        settle_next = 16'h0000;
        if (osc_run) begin
          st_next = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        settle_next = settle_reg + 16'h0001;
        if (!osc_run) begin
          st_next = ST_OFF;
        end else if (settle_reg >= 16'(SETTLE_CYC - 1)) begin
          st_next = ST_READY;
        end
      end
      ST_READY: begin
        if (!osc_run) begin
          st_next = ST_OFF;
        end
      end
      default: st_next = ST_OFF;
    endcase
    if (osc_run) begin
      div_cnt_next = div_cnt_reg + 7'h01;
      tick_next = (div_cnt_reg & div_mask(div_reg)) == div_mask(div_reg);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_OFF;
      settle_reg <= 16'h0000;
      div_cnt_reg <= 7'h00;
      tick_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      settle_reg <= settle_next;
      div_cnt_reg <= div_cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign frdy = (st_reg == ST_READY) && osc_run;

  // Multiplier controls held in flip-flops toward the analog loop
  iosc_mult_t mult_reg, mult_next;

  always_comb begin
    mult_next.en = mul_en_reg;
    mult_next.init = mul_init_reg && mul_en_reg;
    mult_next.src_ext = msel_reg[0];
    // Upper select bit picks x4 from the halved input, else x2 which ignores scale
    mult_next.base_x4 = msel_reg[1];
    mult_next.num = 3'h1;
    mult_next.den = 3'h1;
    if (msel_reg[1] && (scale_reg >= 3'h2)) begin
      mult_next.num = 3'h2;
      mult_next.den = scale_reg;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mult_reg <= '0;
    end else begin
      mult_reg <= mult_next;
    end
  end

  assign sfr_rdata_o = rdata_reg;
  assign osc_o = '{run: osc_run, coarse: coarse_reg, fine: fine_reg};
  assign mult_o = mult_reg;
  assign system_clock_src_o = src_reg;
  assign system_clock_tick_o = tick_reg;
  assign system_clock_stop_o = susp_reg && (src_reg == SRC_INT);

  sequence s_mult_init_write;
    wr_hit(sfr_i, ADDR_MULT) && sfr_i.wdata[MUL_EN_BIT] && sfr_i.wdata[MUL_INIT_BIT];
  endsequence

  property p_osc_off;
    @(posedge core_clk_i) disable iff (!rst_n)
    (osc_en_reg == OSC_EN_OFF) |-> !osc_o.run;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator runs while disabled");

  property p_wake;
    @(posedge core_clk_i) disable iff (!rst_n)
    (wake && !(wr_hit(sfr_i, ADDR_OSC_CTRL) && sfr_i.wdata[SUSP_BIT])) |=> !susp_reg && !system_clock_stop_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake event did not resume");

  property p_frdy;
    @(posedge core_clk_i) disable iff (!rst_n)
    rd_hit(sfr_i, ADDR_OSC_CTRL) && !osc_run |=> !sfr_rdata_o[FRDY_BIT];
  endproperty
  a_frdy: assert property (p_frdy) else $error("ready flag set while stopped");

  property p_div1;
    @(posedge core_clk_i) disable iff (!rst_n)
    (div_reg == DIV_BY_ONE && osc_run) |=> system_clock_tick_o;
  endproperty
  a_div1: assert property (p_div1) else $error("divide by one missed a tick");

  property p_rsvd;
    @(posedge core_clk_i) disable iff (!rst_n)
    rd_hit(sfr_i, ADDR_OSC_CTRL) |=> !sfr_rdata_o[3];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit read nonzero");

  property p_coarse_top;
    @(posedge core_clk_i) disable iff (!rst_n)
    rd_hit(sfr_i, ADDR_COARSE) |=> !sfr_rdata_o[7];
  endproperty
  a_coarse_top: assert property (p_coarse_top) else $error("coarse top bit read nonzero");

  property p_fine_top;
    @(posedge core_clk_i) disable iff (!rst_n)
    rd_hit(sfr_i, ADDR_FINE) |=> sfr_rdata_o[7:6] == 2'h0;
  endproperty
  a_fine_top: assert property (p_fine_top) else $error("fine upper bits read nonzero");

  property p_x2_unscaled;
    @(posedge core_clk_i) disable iff (!rst_n)
    !mult_o.base_x4 |-> mult_o.num == mult_o.den;
  endproperty
  a_x2_unscaled: assert property (p_x2_unscaled) else $error("x2 output was scaled");

  property p_rdy_clear;
    @(posedge core_clk_i) disable iff (!rst_n)
    (wr_hit(sfr_i, ADDR_MULT) && !sfr_i.wdata[MUL_EN_BIT]) |=> ##1 !mul_rdy_reg;
  endproperty
  a_rdy_clear: assert property (p_rdy_clear) else $error("ready kept after disable");

  property p_rdy_lock;
    @(posedge core_clk_i) disable iff (!rst_n)
    s_mult_init_write ##1 (pll_lock_i && mul_en_reg) |=> mul_rdy_reg;
  endproperty
  a_rdy_lock: assert property (p_rdy_lock) else $error("ready missing after lock");
endmodule

/* File: verification/iosc_ctrl_tb.sv */
// Purpose: Self-checking bench for the oscillator and multiplier control registers
// Assumes: Register strobes are driven by NBA at the rising edge, one request at a time
// Notes: Settle count shortened to 4 cycles; lock input is driven by the bench
`timescale 1ns/1ps
module iosc_ctrl_tb;
  import iosc_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  iosc_sfr_t sfr = '0;
  logic p0 = 1'b0;
  logic p1 = 1'b0;
  logic cen = 1'b0;
  logic cout = 1'b1;
  logic lock = 1'b0;
  logic [7:0] rdata;
  iosc_trim_t osc;
  iosc_mult_t mult;
  logic [1:0] src;
  logic tick;
  logic stop;
  int err_count = 0;
  int num_checks = 0;

  always #4 core_clk_i = ~core_clk_i;

  iosc_ctrl #(.SETTLE_CYC(4)) dut_u (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sfr_i(sfr), .port0_match_i(p0), .port1_match_i(p1),
    .cmp0_en_i(cen), .cmp0_out_i(cout), .pll_lock_i(lock), .sfr_rdata_o(rdata), .osc_o(osc),
    .mult_o(mult), .system_clock_src_o(src), .system_clock_tick_o(tick), .system_clock_stop_o(stop)
  );

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    sfr <= '{a, 1'b1, 1'b0, d};
    @(posedge core_clk_i);
    sfr.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    sfr <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge core_clk_i);
    sfr.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Bounded poll; running out ends the run
  task automatic poll(input string name, input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] d;
    int n;
    n = 0;
    rd(a, d);
    while ((d & m) !== exp && n < 20) begin
      rd(a, d);
      n++;
    end
    chk(name, d & m, exp);
    if ((d & m) !== exp) begin
      give_verdict();
    end
  endtask

  task automatic wake(input logic a, input logic b, input logic c, input logic o, input logic exp_run);
    wr(ADDR_OSC_CTRL, 8'he7);
    @(posedge core_clk_i);
    #1;
    chk("run_suspended", osc.run, 1'b0);
    chk("stop_suspended", stop, 1'b1);
    @(posedge core_clk_i);
    p0 <= a;
    p1 <= b;
    cen <= c;
    cout <= o;
    @(posedge core_clk_i);
    p0 <= 1'b0;
    p1 <= 1'b0;
    cen <= 1'b0;
    cout <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk("run_after_event", osc.run, exp_run);
    chk("stop_after_event", stop, !exp_run);
  endtask

  initial begin
    logic [7:0] d;
    logic [2:0] num;
    logic [2:0] den;
    int cnt;
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    poll("osc_ctrl_reset", ADDR_OSC_CTRL, 8'hff, 8'hd0);
    rd(ADDR_COARSE, d);
    chk("coarse_reset", d, {1'b0, COARSE_RST});
    rd(ADDR_FINE, d);
    chk("fine_reset", d, {2'h0, FINE_RST});
    rd(ADDR_MULT, d);
    chk("mult_reset", d, 8'h00);
    rd(8'h55, d);
    chk("unmapped_read", d, 8'h00);
    $display("test reset done");
    wr(ADDR_COARSE, 8'hff);
    rd(ADDR_COARSE, d);
    chk("coarse_top_bit", d, 8'h7f);
    chk("coarse_out", osc.coarse, 7'h7f);
    wr(ADDR_FINE, 8'hff);
    rd(ADDR_FINE, d);
    chk("fine_upper_bits", d, 8'h3f);
    chk("fine_out", osc.fine, 6'h3f);
    wr(ADDR_FINE, 8'h00);
    rd(ADDR_FINE, d);
    chk("fine_zero", d, 8'h00);
    $display("test trim done");
    wr(ADDR_OSC_CTRL, 8'h07);
    rd(ADDR_OSC_CTRL, d);
    chk("osc_disabled", d, 8'h07);
    chk("run_disabled", osc.run, 1'b0);
    wr(ADDR_OSC_CTRL, 8'hc7);
    poll("reserved_bit_zero", ADDR_OSC_CTRL, 8'hff, 8'hd7);
    chk("run_enabled", osc.run, 1'b1);
    $display("test enable done");
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_OSC_CTRL, 8'hc0 | 8'(k));
      repeat (2) @(posedge core_clk_i);
      cnt = 0;
      repeat (256) begin
        @(posedge core_clk_i);
        #1;
        cnt += int'(tick);
      end
      chk("tick_count", 16'(cnt), 16'(2 << k));
    end
    $display("test divider done");
    wake(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    wake(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    wake(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    wake(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    wake(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    $display("test suspend done");
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 8; k++) begin
        wr(ADDR_MULT, 8'h00);
        wr(ADDR_MULT, 8'(k << 2) | 8'(s));
        wr(ADDR_MULT, 8'h80 | 8'(k << 2) | 8'(s));
        repeat (2) @(posedge core_clk_i);
        #1;
        num = (s >= 2 && k >= 2) ? 3'h2 : 3'h1;
        den = (s >= 2 && k >= 2) ? 3'(k) : 3'h1;
        chk("mult_ctrl", {6'h00, mult}, {6'h00, 1'b1, 1'b0, s[0], s[1], num, den});
      end
    end
    $display("test scaling done");
    // Internal x4 unscaled gives 48 MHz, inside the core range
    wr(ADDR_MULT, 8'h00);
    wr(ADDR_MULT, 8'h02);
    wr(ADDR_MULT, 8'h82);
    repeat (640) @(posedge core_clk_i);
    // Internal input, so no external source has to settle first
    wr(ADDR_MULT, 8'hc2);
    rd(ADDR_MULT, d);
    chk("ready_before_lock", d & 8'h20, 8'h00);
    @(posedge core_clk_i);
    lock <= 1'b1;
    poll("ready_after_lock", ADDR_MULT, 8'h20, 8'h20);
    wr(ADDR_MULT, 8'h00);
    rd(ADDR_MULT, d);
    chk("ready_disabled", d & 8'h20, 8'h00);
    wr(ADDR_MULT, 8'h02);
    wr(ADDR_MULT, 8'h82);
    repeat (4) @(posedge core_clk_i);
    rd(ADDR_MULT, d);
    chk("ready_without_init", d & 8'h20, 8'h00);
    repeat (640) @(posedge core_clk_i);
    wr(ADDR_MULT, 8'hc2);
    poll("ready_after_reinit", ADDR_MULT, 8'h20, 8'h20);
    $display("test bring-up done");
    wr(ADDR_SRC_SEL, 8'h01);
    rd(ADDR_SRC_SEL, d);
    chk("src_ext", d, 8'h01);
    wr(ADDR_SRC_SEL, 8'h02);
    wr(ADDR_SRC_SEL, 8'h03);
    rd(ADDR_SRC_SEL, d);
    chk("src_reserved_kept", d, 8'h02);
    chk("src_out", src, SRC_MULT);
    wr(ADDR_SRC_SEL, 8'hfc);
    rd(ADDR_SRC_SEL, d);
    chk("src_int", d, 8'h00);
    $display("test source done");
    give_verdict();
  end
endmodule
